/* dma_channel_config_control.sv */
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// [RL1] error events raise the interrupt only while error_irq_enable is 1.
// [RL2] the three-bit flow field picks memory-memory, memory-peripheral or peripheral-memory.
// [RL3] dest_request_line picks the destination request and is ignored when memory is the sink.
// [RL4] src_request_line picks the source request and is ignored when memory is the source.
// [RL5] the channel runs while its enable bit is 1, and in memory flow writing 1 starts it.
// [RL6] the enable bit clears itself when the remaining transfer count reaches zero.
// [RL7] disabling mid-transfer flushes the channel fifo and software must reprogram the channel.
// [RL8] software pauses by setting hold, waiting for the fifo flag to drop, then disabling.
// [RL9] in memory-to-memory flow peripheral requests never start the channel.
// [RL10] the hold bit at position 18 blocks all incoming requests while it is 1.
// [RL11] the read-only flag at position 17 is 1 while the channel fifo holds data.
// [RL12] reserved configuration bits are written as zero and have no effect.
module dma_channel_config_control #(
    parameter int CNT_W = dma_cfg_pkg::CNT_W,
    parameter int REQ_LINES = dma_cfg_pkg::REQ_LINES
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // peripheral request pins
    input wire logic [REQ_LINES-1:0] src_req_pin,
    input wire logic [REQ_LINES-1:0] dst_req_pin,
    // datapath status
    input wire logic beat_done,
    input wire logic fifo_has_data,
    input wire logic chan_err,
    // datapath control
    output logic chan_run,
    output logic [2:0] flow_mode,
    output logic src_req_out,
    output logic dst_req_out,
    output logic m2m_start,
    output logic fifo_flush,
    output logic irq
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    dma_cfg_pkg::chan_state_t state_ff, nxt_state;
    logic en_ff, nxt_en;
    logic halt_ff, nxt_halt;
    logic err_ie_ff, nxt_err_ie;
    logic tc_ie_ff, nxt_tc_ie;
    logic [2:0] flow_ff, nxt_flow;
    logic [3:0] src_line_ff, nxt_src_line;
    logic [3:0] dst_line_ff, nxt_dst_line;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [1:0] stat_ff, nxt_stat;
    logic [1:0] mask_ff, nxt_mask;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, pslverr_ff, nxt_pslverr;
    logic src_req_ff, dst_req_ff, start_ff, flush_ff, irq_ff;
    logic [REQ_LINES-1:0] src_sync, dst_sync;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    // ---------------------------------------------------------------
    // request pin synchronisers
    // ---------------------------------------------------------------
    req_sync #(.WIDTH(REQ_LINES)) u_src_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(src_req_pin),
        .sync_out(src_sync)
    );

    req_sync #(.WIDTH(REQ_LINES)) u_dst_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(dst_req_pin),
        .sync_out(dst_sync)
    );

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire setup = psel && !penable;
    wire acc = psel && penable && pready_ff;
    wire wr = acc && pwrite;
    wire wr_cfg = wr && hit(paddr, dma_cfg_pkg::CFG_OFF);
    wire wr_cnt = wr && hit(paddr, dma_cfg_pkg::CNT_OFF);
    wire wr_stat = wr && hit(paddr, dma_cfg_pkg::STAT_OFF);
    wire wr_mask = wr && hit(paddr, dma_cfg_pkg::MASK_OFF);
    wire mapped = hit(paddr, dma_cfg_pkg::CFG_OFF) || hit(paddr, dma_cfg_pkg::CNT_OFF)
        || hit(paddr, dma_cfg_pkg::STAT_OFF) || hit(paddr, dma_cfg_pkg::MASK_OFF);
    wire wr_en_bit = pwdata[dma_cfg_pkg::EN_BIT];
    wire [2:0] wr_flow = pwdata[dma_cfg_pkg::FLOW_LSB +: dma_cfg_pkg::FLOW_W];

    // ---------------------------------------------------------------
    // channel control
    // ---------------------------------------------------------------
    wire flow_m2m = (flow_ff == dma_cfg_pkg::FLOW_M2M); // RL2
    wire flow_m2p = (flow_ff == dma_cfg_pkg::FLOW_M2P); // RL2
    wire flow_p2m = (flow_ff == dma_cfg_pkg::FLOW_P2M); // RL2
    wire last_beat = en_ff && beat_done && (cnt_ff == CNT_W'(1)); // RL6
    wire sw_start = wr_cfg && wr_en_bit && !en_ff;
    wire sw_stop = wr_cfg && !wr_en_bit && en_ff;
    wire mid_stop = sw_stop && (cnt_ff != '0); // RL7
    wire req_open = en_ff && !halt_ff; // RL10
    wire src_pick = src_sync[src_line_ff]; // RL4
    wire dst_pick = dst_sync[dst_line_ff]; // RL3
    wire err_evt = chan_err && en_ff && err_ie_ff; // RL1
    wire tc_evt = last_beat && tc_ie_ff;
    wire [1:0] evt_vec = {tc_evt, err_evt};
    wire [31:0] cfg_view = {13'h0000, halt_ff, fifo_has_data, 1'b0, tc_ie_ff, err_ie_ff,
        flow_ff, 1'b0, dst_line_ff, 1'b0, src_line_ff, en_ff}; // RL11 RL12

    always_comb
    begin
        nxt_en = en_ff;
        nxt_halt = halt_ff;
        nxt_err_ie = err_ie_ff;
        nxt_tc_ie = tc_ie_ff;
        nxt_flow = flow_ff;
        nxt_src_line = src_line_ff;
        nxt_dst_line = dst_line_ff;
        nxt_state = state_ff;
        if (wr_cfg)
        begin
            // reserved bits are simply not stored
            nxt_en = wr_en_bit; // RL5
            nxt_halt = pwdata[dma_cfg_pkg::HALT_BIT]; // RL10
            nxt_err_ie = pwdata[dma_cfg_pkg::ERR_IE_BIT]; // RL1
            nxt_tc_ie = pwdata[dma_cfg_pkg::TC_IE_BIT];
            nxt_flow = wr_flow; // RL2
            nxt_src_line = pwdata[dma_cfg_pkg::SRC_LSB +: dma_cfg_pkg::LINE_W]; // RL4
            nxt_dst_line = pwdata[dma_cfg_pkg::DST_LSB +: dma_cfg_pkg::LINE_W]; // RL3
        end
        if (last_beat)
        begin
            nxt_en = 1'b0; // RL6
        end
        case (state_ff)
            dma_cfg_pkg::ST_IDLE: if (nxt_en) nxt_state = dma_cfg_pkg::ST_RUN;
            dma_cfg_pkg::ST_RUN: if (!nxt_en) nxt_state = dma_cfg_pkg::ST_IDLE;
            default: nxt_state = dma_cfg_pkg::ST_IDLE;
        endcase
    end

    assign nxt_cnt = wr_cnt ? pwdata[CNT_W-1:0]
        : (en_ff && beat_done && cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
    // set wins over clear
    assign nxt_stat = (wr_stat ? (stat_ff & ~pwdata[1:0]) : stat_ff) | evt_vec;
    assign nxt_mask = wr_mask ? pwdata[1:0] : mask_ff;
    assign nxt_pslverr = setup && !mapped;

    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        if (hit(paddr, dma_cfg_pkg::CFG_OFF))
            nxt_prdata = cfg_view;
        else if (hit(paddr, dma_cfg_pkg::CNT_OFF))
            nxt_prdata = 32'(cnt_ff);
        else if (hit(paddr, dma_cfg_pkg::STAT_OFF))
            nxt_prdata = {30'h0000_0000, stat_ff};
        else if (hit(paddr, dma_cfg_pkg::MASK_OFF))
            nxt_prdata = {30'h0000_0000, mask_ff};
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= dma_cfg_pkg::ST_IDLE;
            en_ff <= dma_cfg_pkg::CFG_RESET[dma_cfg_pkg::EN_BIT];
            halt_ff <= dma_cfg_pkg::CFG_RESET[dma_cfg_pkg::HALT_BIT];
            err_ie_ff <= dma_cfg_pkg::CFG_RESET[dma_cfg_pkg::ERR_IE_BIT];
            tc_ie_ff <= dma_cfg_pkg::CFG_RESET[dma_cfg_pkg::TC_IE_BIT];
            flow_ff <= dma_cfg_pkg::FLOW_M2M;
            src_line_ff <= 4'h0;
            dst_line_ff <= 4'h0;
            cnt_ff <= CNT_W'(dma_cfg_pkg::CNT_RESET);
            stat_ff <= dma_cfg_pkg::IRQ_RESET;
            mask_ff <= dma_cfg_pkg::IRQ_RESET;
        end
        else if (ce)
        begin
            state_ff <= nxt_state;
            en_ff <= nxt_en;
            halt_ff <= nxt_halt;
            err_ie_ff <= nxt_err_ie;
            tc_ie_ff <= nxt_tc_ie;
            flow_ff <= nxt_flow;
            src_line_ff <= nxt_src_line;
            dst_line_ff <= nxt_dst_line;
            cnt_ff <= nxt_cnt;
            stat_ff <= nxt_stat;
            mask_ff <= nxt_mask;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            src_req_ff <= 1'b0;
            dst_req_ff <= 1'b0;
            start_ff <= 1'b0;
            flush_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else if (ce)
        begin
            prdata_ff <= setup ? nxt_prdata : prdata_ff;
            pready_ff <= setup;
            pslverr_ff <= nxt_pslverr;
            src_req_ff <= req_open && flow_p2m && src_pick; // RL4 RL9 RL10
            dst_req_ff <= req_open && flow_m2p && dst_pick; // RL3 RL9 RL10
            start_ff <= sw_start && (wr_flow == dma_cfg_pkg::FLOW_M2M); // RL5 RL9
            flush_ff <= mid_stop; // RL7
            irq_ff <= |(nxt_stat & nxt_mask);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign chan_run = en_ff;
    assign flow_mode = flow_ff;
    assign src_req_out = src_req_ff;
    assign dst_req_out = dst_req_ff;
    assign m2m_start = start_ff;
    assign fifo_flush = flush_ff;
    assign irq = irq_ff;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_m2m_write;
        ce && wr_cfg && wr_en_bit && !en_ff && (wr_flow == dma_cfg_pkg::FLOW_M2M);
    endsequence

    sequence s_mid_stop;
        ce && wr_cfg && !wr_en_bit && en_ff && (cnt_ff != '0);
    endsequence

    AST_AUTO_CLEAR: assert property ( // RL6
        (ce && last_beat) |=> (!en_ff && cnt_ff == '0))
        else $error("enable not cleared at count zero");

    AST_ERR_GATE: assert property ( // RL1
        (ce && chan_err && en_ff) |=> (stat_ff[dma_cfg_pkg::IRQ_ERR_BIT] == $past(err_ie_ff)
            || $past(stat_ff[dma_cfg_pkg::IRQ_ERR_BIT])))
        else $error("error status does not follow its enable");

    AST_M2M_START: assert property ( // RL5
        s_m2m_write |=> (m2m_start && en_ff))
        else $error("memory flow start pulse missing");

    AST_M2M_NO_REQ: assert property ( // RL9
        (ce && flow_m2m) |=> (!src_req_out && !dst_req_out))
        else $error("request passed in memory flow");

    AST_HOLD_BLOCKS: assert property ( // RL10
        (ce && halt_ff) |=> (!src_req_out && !dst_req_out))
        else $error("request passed while held");

    AST_FLUSH: assert property ( // RL7
        s_mid_stop |=> (fifo_flush && !chan_run) ##1 (!fifo_flush || $past(mid_stop)))
        else $error("fifo not flushed on mid-transfer stop");

    AST_SRC_SEL: assert property ( // RL4
        (ce && req_open && flow_p2m) |=> (src_req_out == $past(src_pick)) && !dst_req_out)
        else $error("source request selection wrong");

    AST_DST_SEL: assert property ( // RL3
        (ce && req_open && flow_m2p) |=> (dst_req_out == $past(dst_pick)) && !src_req_out)
        else $error("destination request selection wrong");

    AST_BUSY_FLAG: assert property ( // RL11
        (ce && setup && hit(paddr, dma_cfg_pkg::CFG_OFF))
            |=> (prdata[dma_cfg_pkg::BUSY_BIT] == $past(fifo_has_data)))
        else $error("fifo flag reads wrong");

    AST_IRQ_LEVEL: assert property ( // RL1
        ce |=> (irq == |(stat_ff & mask_ff)))
        else $error("interrupt level wrong");

    AST_STATE_TRACK: assert property ( // RL5
        ce |=> ((state_ff == dma_cfg_pkg::ST_RUN) == en_ff))
        else $error("channel state does not follow enable");

endmodule

/* dma_cfg_pkg.sv */
package dma_cfg_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] CFG_OFF = 12'h000;
    localparam logic [11:0] CNT_OFF = 12'h004;
    localparam logic [11:0] STAT_OFF = 12'h008;
    localparam logic [11:0] MASK_OFF = 12'h00C;

    // ---------------------------------------------------------------
    // channel_config_word fields
    // ---------------------------------------------------------------
    localparam int EN_BIT = 0;
    localparam int SRC_LSB = 1;
    localparam int LINE_W = 4;
    localparam int DST_LSB = 6;
    localparam int FLOW_LSB = 11;
    localparam int FLOW_W = 3;
    localparam int ERR_IE_BIT = 14;
    localparam int TC_IE_BIT = 15;
    localparam int BUSY_BIT = 17;
    localparam int HALT_BIT = 18;
    localparam int REQ_LINES = 16;

    // ---------------------------------------------------------------
    // flow codes, status bits, reset values
    // ---------------------------------------------------------------
    localparam logic [2:0] FLOW_M2M = 3'h0;
    localparam logic [2:0] FLOW_M2P = 3'h1;
    localparam logic [2:0] FLOW_P2M = 3'h2;
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_TC_BIT = 1;
    localparam int IRQ_W = 2;
    localparam int CNT_W = 12;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [11:0] CNT_RESET = 12'h000;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    typedef enum logic {ST_IDLE, ST_RUN} chan_state_t;

endpackage

/* req_sync.sv */
`timescale 1ns/10ps
module req_sync #(
    parameter int WIDTH = 16
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else if (ce)
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

/* dma_far_side.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------
// far side: request pins and datapath status
// ---------------------------------------------------------------
module dma_far_side (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands
    input wire logic [15:0] src_lvl,
    input wire logic [15:0] dst_lvl,
    input wire logic beat_go,
    input wire logic err_go,
    input wire logic slow,
    // from the channel
    input wire logic fifo_flush,
    // to the channel
    output logic [15:0] src_req_pin,
    output logic [15:0] dst_req_pin,
    output logic beat_done,
    output logic fifo_has_data,
    output logic chan_err
);
    logic [2:0] dly_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_req_pin <= 16'h0000;
            dst_req_pin <= 16'h0000;
            beat_done <= 1'b0;
            fifo_has_data <= 1'b0;
            chan_err <= 1'b0;
            dly_ff <= 3'h0;
        end
        else
        begin
            src_req_pin <= src_lvl;
            dst_req_pin <= dst_lvl;
            chan_err <= err_go;
            beat_done <= 1'b0;
            if (beat_go)
            begin
                fifo_has_data <= 1'b1;
                dly_ff <= slow ? 3'h7 : 3'h1;
            end
            else if (dly_ff != 3'h0)
            begin
                dly_ff <= dly_ff - 3'h1;
                beat_done <= (dly_ff == 3'h1);
                fifo_has_data <= (dly_ff != 3'h1);
            end
            if (fifo_flush)
            begin
                fifo_has_data <= 1'b0;
                dly_ff <= 3'h0;
            end
        end
    end
endmodule

/* dma_channel_config_control_bench.sv */
`timescale 1ns/10ps
module dma_channel_config_control_bench;
    // ---------------------------------------------------------------
    // signals and model state
    // ---------------------------------------------------------------
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat, w;
    logic pready, pslverr, rerr, beat_done, fifo_has_data, chan_err, chan_run;
    logic src_req_out, dst_req_out, m2m_start, fifo_flush, irq;
    logic [2:0] flow_mode;
    logic [15:0] src_lvl = 16'h0000, dst_lvl = 16'h0000, src_req_pin, dst_req_pin;
    logic beat_go = 1'b0, err_go = 1'b0, slow = 1'b0;
    int cfg, cnt, stat, msk, exp_m2m, exp_flush, m2m_seen, flush_seen, s, d;
    int failures, samples_checked;
    // ---------------------------------------------------------------
    // design and far side
    // ---------------------------------------------------------------
    dma_channel_config_control dma_channel_config_control_i (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req_pin(src_req_pin), .dst_req_pin(dst_req_pin), .beat_done(beat_done),
        .fifo_has_data(fifo_has_data), .chan_err(chan_err), .chan_run(chan_run),
        .flow_mode(flow_mode), .src_req_out(src_req_out), .dst_req_out(dst_req_out),
        .m2m_start(m2m_start), .fifo_flush(fifo_flush), .irq(irq));
    dma_far_side dma_far_side_i (.pclk(pclk), .presetn(presetn), .src_lvl(src_lvl),
        .dst_lvl(dst_lvl), .beat_go(beat_go), .err_go(err_go), .slow(slow),
        .fifo_flush(fifo_flush), .src_req_pin(src_req_pin), .dst_req_pin(dst_req_pin),
        .beat_done(beat_done), .fifo_has_data(fifo_has_data), .chan_err(chan_err));
    initial
    begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (m2m_start === 1'b1) m2m_seen++;
        if (fifo_flush === 1'b1) flush_seen++;
    end
    // ---------------------------------------------------------------
    // compare, bus and model tasks
    // ---------------------------------------------------------------
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
        chk_reg(got, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] dat);
        int nw;
        apb(1'b1, a, dat);
        nw = dat & 32'h0004_FBDF;
        if (a == dma_cfg_pkg::CFG_OFF)
        begin
            if (!cfg[0] && nw[0] && nw[13:11] == 0) exp_m2m++;
            if (cfg[0] && !nw[0] && cnt != 0) exp_flush++;
            cfg = nw;
        end
        else if (a == dma_cfg_pkg::CNT_OFF) cnt = dat & 32'h0000_0FFF;
        else if (a == dma_cfg_pkg::STAT_OFF) stat = stat & ~dat;
        else if (a == dma_cfg_pkg::MASK_OFF) msk = dat & 32'h0000_0003;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_reg(rdat, exp);
        chk_pin(32'(rerr), 32'h0000_0000);
    endtask
    task automatic check_state();
        idle(2);
        chk_pin(32'(chan_run), 32'(cfg[0]));
        chk_pin(32'(flow_mode), 32'(cfg[13:11]));
        chk_pin(32'(irq), 32'((stat & msk) != 0));
        chk_pin(32'(m2m_seen), 32'(exp_m2m));
        chk_pin(32'(flush_seen), 32'(exp_flush));
    endtask
    task automatic beat(input logic sl);
        @(posedge pclk);
        beat_go <= 1'b1;
        slow <= sl;
        @(posedge pclk);
        beat_go <= 1'b0;
        if (sl) rd(dma_cfg_pkg::CFG_OFF, 32'(cfg) | 32'h0002_0000);
        idle(10);
        if (cfg[0] && cnt != 0) cnt--;
        if (cfg[0] && cnt == 0) stat = stat | (cfg[15] ? 2 : 0);
        if (cnt == 0) cfg = cfg & ~1;
        check_state();
        rd(dma_cfg_pkg::CNT_OFF, 32'(cnt));
    endtask
    task automatic fault();
        @(posedge pclk);
        err_go <= 1'b1;
        @(posedge pclk);
        err_go <= 1'b0;
        idle(3);
        if (cfg[0] && cfg[14]) stat = stat | 1;
        check_state();
    endtask
    task automatic close_out();
        $display("samples_checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        close_out();
    end
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial
    begin
        void'($urandom(23784));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0000_0000);
        apb(1'b1, 12'h010, 32'hFFFF_FFFF);
        chk_pin(32'(rerr), 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk_reg(rdat, 32'h0000_0000);
        wr(dma_cfg_pkg::CFG_OFF, 32'hFFF8_0420);
        rd(dma_cfg_pkg::CFG_OFF, 32'h0000_0000);
        for (int f = 0; f < 8; f++)
        begin
            s = $urandom_range(15);
            d = $urandom_range(15);
            w = 32'(1 | (s << 1) | (d << 6) | (f << 11));
            wr(dma_cfg_pkg::CNT_OFF, 32'($urandom_range(4095, 1)));
            wr(dma_cfg_pkg::CFG_OFF, w);
            src_lvl <= 16'(1 << s);
            dst_lvl <= 16'(1 << d);
            idle(5);
            chk_pin(32'(src_req_out), 32'(f == 2));
            chk_pin(32'(dst_req_out), 32'(f == 1));
            check_state();
            rd(dma_cfg_pkg::CFG_OFF, w);
            src_lvl <= ~16'(1 << s);
            dst_lvl <= ~16'(1 << d);
            idle(5);
            chk_pin(32'(src_req_out), 32'h0000_0000);
            chk_pin(32'(dst_req_out), 32'h0000_0000);
            src_lvl <= 16'hFFFF;
            dst_lvl <= 16'hFFFF;
            wr(dma_cfg_pkg::CFG_OFF, w | 32'h0004_0000);
            idle(5);
            chk_pin(32'(src_req_out), 32'h0000_0000);
            chk_pin(32'(dst_req_out), 32'h0000_0000);
            rd(dma_cfg_pkg::CFG_OFF, w | 32'h0004_0000);
            wr(dma_cfg_pkg::CFG_OFF, 32'h0000_0000);
            check_state();
        end
        wr(dma_cfg_pkg::MASK_OFF, 32'h0000_0003);
        wr(dma_cfg_pkg::CNT_OFF, 32'h0000_0003);
        wr(dma_cfg_pkg::CFG_OFF, 32'h0000_D001);
        fault();
        wr(dma_cfg_pkg::STAT_OFF, 32'h0000_0001);
        check_state();
        wr(dma_cfg_pkg::MASK_OFF, 32'h0000_0000);
        for (int i = 0; i < 3; i++) beat(i != 1);
        rd(dma_cfg_pkg::STAT_OFF, 32'(stat));
        wr(dma_cfg_pkg::MASK_OFF, 32'h0000_0003);
        check_state();
        wr(dma_cfg_pkg::STAT_OFF, 32'h0000_0002);
        check_state();
        wr(dma_cfg_pkg::CNT_OFF, 32'h0000_0005);
        wr(dma_cfg_pkg::CFG_OFF, 32'h0000_1001);
        fault();
        rd(dma_cfg_pkg::STAT_OFF, 32'(stat));
        close_out();
    end
endmodule
